// file: logic/lsi_pkg.sv
package lsi_pkg;

    // Register bus geometry
    localparam int          ADDR_W            = 8;
    localparam int          DATA_W            = 16;

    // Register offsets
    localparam logic [7:0]  OFS_RESULT        = 8'h00;
    localparam logic [7:0]  OFS_CONFIG        = 8'h01;
    localparam logic [7:0]  OFS_LOW_LIMIT     = 8'h02;
    localparam logic [7:0]  OFS_HIGH_LIMIT    = 8'h03;
    localparam logic [7:0]  OFS_IRQ_STATUS    = 8'h04;
    localparam logic [7:0]  OFS_IRQ_ENABLE    = 8'h05;
    localparam logic [7:0]  OFS_IRQ_CLEAR     = 8'h06;

    // Configuration register fields
    localparam int          CFG_FAULT_LSB     = 0;
    localparam int          CFG_POL_BIT       = 2;
    localparam int          CFG_LATCH_BIT     = 3;
    localparam int          CFG_FLAG_LOW_BIT  = 5;
    localparam int          CFG_FLAG_HIGH_BIT = 6;
    localparam int          CFG_CONV_RDY_BIT  = 7;
    localparam int          CFG_MODE_LSB      = 9;

    // Exponent on top, mantissa below
    localparam int          EXP_LSB           = 12;
    localparam int          EXP_TOP_LSB       = 14;
    localparam int          MANT_W            = 12;
    localparam int          LIN_W             = 27;
    localparam logic [1:0]  EOC_CODE          = 2'h3;
    localparam logic [1:0]  MODE_SHUTDOWN     = 2'h0;

    // Reset values
    localparam logic [15:0] RST_RESULT        = 16'h0000;
    localparam logic [15:0] RST_LOW_LIMIT     = 16'h0000;
    localparam logic [15:0] RST_HIGH_LIMIT    = 16'hBFFF;
    localparam logic [1:0]  RST_FAULT_SEL     = 2'h0;
    localparam logic [1:0]  RST_MODE          = 2'h0;
    localparam logic        RST_POL           = 1'b0;
    localparam logic        RST_LATCH         = 1'b1;

    // Consecutive conversions per fault-count code
    localparam int          FAULT_NEED_0      = 1;
    localparam int          FAULT_NEED_1      = 2;
    localparam int          FAULT_NEED_2      = 4;
    localparam int          FAULT_NEED_3      = 8;
    localparam int          FAULT_CNT_W       = 4;

    // Interrupt event bits
    localparam int          IRQ_N             = 4;
    localparam int          IRQ_CONV_BIT      = 0;
    localparam int          IRQ_HIGH_BIT      = 1;
    localparam int          IRQ_LOW_BIT       = 2;
    localparam int          IRQ_ALERT_BIT     = 3;

    typedef enum logic {
        PIN_INACTIVE = 1'b0,
        PIN_ACTIVE   = 1'b1
    } lsi_pin_state_t;

endpackage

// file: logic/lsi_fault_counter.sv
`timescale 1ns/100ps
module lsi_fault_counter #(
    parameter int CNT_W = 4
) (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       reset_n_in,
    // Comparison per conversion
    input  wire logic       sample_in,
    input  wire logic       above_in,
    input  wire logic       below_in,
    input  wire logic [1:0] fault_sel_in,
    // Criterion met, valid with sample_in
    output logic            high_met_out,
    output logic            low_met_out
);

    logic [CNT_W-1:0] above_cnt_ff;
    logic [CNT_W-1:0] below_cnt_ff;
    logic [CNT_W-1:0] need;

    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] cnt);
        sat_inc = (cnt == {CNT_W{1'b1}}) ? cnt : cnt + 1'b1;
    endfunction

    always_comb begin
        case (fault_sel_in)
            2'h0:    need = CNT_W'(lsi_pkg::FAULT_NEED_0);
            2'h1:    need = CNT_W'(lsi_pkg::FAULT_NEED_1);
            2'h2:    need = CNT_W'(lsi_pkg::FAULT_NEED_2);
            2'h3:    need = CNT_W'(lsi_pkg::FAULT_NEED_3);
            default: need = CNT_W'(lsi_pkg::FAULT_NEED_0);
        endcase
    end

    // A conversion that does not exceed restarts the run
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            above_cnt_ff <= '0;
        end else if (sample_in) begin
            above_cnt_ff <= above_in ? sat_inc(above_cnt_ff) : '0;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            below_cnt_ff <= '0;
        end else if (sample_in) begin
            below_cnt_ff <= below_in ? sat_inc(below_cnt_ff) : '0;
        end
    end

    assign high_met_out = sample_in && above_in && (sat_inc(above_cnt_ff) >= need);
    assign low_met_out  = sample_in && below_in && (sat_inc(below_cnt_ff) >= need);

endmodule

// file: logic/lsi_event_irq.sv
`timescale 1ns/100ps
module lsi_event_irq #(
    parameter int N = 4
) (
    // Clock and reset
    input  wire logic         clk_in,
    input  wire logic         reset_n_in,
    // Event pulses
    input  wire logic [N-1:0] event_in,
    // Register writes
    input  wire logic         clear_wr_in,
    input  wire logic         enable_wr_in,
    input  wire logic [N-1:0] wr_data_in,
    // State
    output logic [N-1:0]      status_out,
    output logic [N-1:0]      enable_out,
    output logic              irq_out
);

    logic [N-1:0] status_ff;
    logic [N-1:0] enable_ff;
    logic [N-1:0] clear_mask;

    assign clear_mask = clear_wr_in ? wr_data_in : '0;

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            status_ff <= '0;
        end else begin
            status_ff <= (status_ff & ~clear_mask) | event_in;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            enable_ff <= '0;
        end else if (enable_wr_in) begin
            enable_ff <= wr_data_in;
        end
    end

    assign status_out = status_ff;
    assign enable_out = enable_ff;
    assign irq_out    = |(status_ff & enable_ff);

endmodule

// file: logic/lsi_interrupt_core.sv
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/100ps

// What this block does
// - Pin is low for active with polarity 0, or inactive with polarity 1.
// - Configuration read clears conversion-ready right after the read.
// - Low-limit top bits equal to 11b select end-of-conversion mode.
// - End-of-conversion: each conversion sets ready, activates the pin.
// - End-of-conversion pin goes inactive on config read, transparent run write, latched alert.
// - Latched end-of-conversion: high sets flag-high, low sets flag-low, pin active.
// - Transparent end-of-conversion: flags set exclusively, pin active, ready set.
// - Shutdown configuration write changes no flag or ready; it changes pin state only on a latch drop outside end-of-conversion.
// - Run-mode write clears ready; pin inactive under transparent end-of-conversion, or on a latch drop outside end-of-conversion.
// - Alert response clears pin when latched; transparent ignores it.
// - End-of-conversion works with both transparent and latched comparison.
// - Criterion met after fault-count consecutive conversions beyond the limit.
// - Alert response answered only while latch select is 1.
module lsi_interrupt_core (
    // Clock and reset
    input  wire logic        CLK_IN,
    input  wire logic        RESET_N_IN,
    // Register port
    input  wire logic [7:0]  ADDR_IN,
    input  wire logic [15:0] WR_DATA_IN,
    input  wire logic        WR_EN_IN,
    input  wire logic        RD_EN_IN,
    output logic      [15:0] RD_DATA_OUT,
    // Conversion engine
    input  wire logic        CONV_DONE_IN,
    input  wire logic [15:0] RESULT_IN,
    output logic      [1:0]  CONV_MODE_OUT,
    // Alert response from the serial engine
    input  wire logic        ALERT_RESP_IN,
    output logic             ALERT_ACK_OUT,
    output logic             ALERT_FLAG_HIGH_OUT,
    // Interrupts
    output logic             INT_PIN_OUT,
    output logic             IRQ_OUT
);

    // Configuration fields
    logic [1:0]                 fault_sel_ff;
    logic                       polarity_select_ff;
    logic                       latch_ff;
    logic [1:0]                 conv_mode_ff;

    // Limits and result
    logic [15:0]                low_limit_ff;
    logic [15:0]                high_limit_ff;
    logic [15:0]                result_ff;

    // Reported state
    logic                       flag_high_ff;
    logic                       flag_low_ff;
    logic                       conv_ready_ff;
    lsi_pkg::lsi_pin_state_t    int_state_ff;
    logic                       int_pin_ff;
    logic                       alert_ack_ff;
    logic                       alert_flag_high_ff;
    logic [15:0]                rd_data_ff;

    // Next values
    logic                       nxt_flag_high;
    logic                       nxt_flag_low;
    logic                       nxt_conv_ready;
    lsi_pkg::lsi_pin_state_t    nxt_int_state;
    logic [15:0]                nxt_rd_data;

    // Decoded accesses
    logic                       cfg_wr;
    logic                       cfg_rd;
    logic                       low_wr;
    logic                       high_wr;
    logic                       irq_en_wr;
    logic                       irq_clr_wr;
    logic [1:0]                 wr_mode;
    logic                       wr_latch;
    logic                       eoc_mode;
    logic                       alert_taken;

    // Comparison
    logic                       above_high;
    logic                       below_low;
    logic                       high_met;
    logic                       low_met;

    // Interrupt registers
    logic [lsi_pkg::IRQ_N-1:0]  irq_events;
    logic [lsi_pkg::IRQ_N-1:0]  irq_status;
    logic [lsi_pkg::IRQ_N-1:0]  irq_enable;

    // Exponent and mantissa to a linear value
    function automatic logic [26:0] lsi_linear(input logic [15:0] v);
        lsi_linear = {15'h0000, v[lsi_pkg::MANT_W-1:0]} << v[15:lsi_pkg::EXP_LSB];
    endfunction

    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
        addr_hit = (addr == ofs);
    endfunction

    assign cfg_wr     = WR_EN_IN && addr_hit(ADDR_IN, lsi_pkg::OFS_CONFIG);
    assign cfg_rd     = RD_EN_IN && addr_hit(ADDR_IN, lsi_pkg::OFS_CONFIG);
    assign low_wr     = WR_EN_IN && addr_hit(ADDR_IN, lsi_pkg::OFS_LOW_LIMIT);
    assign high_wr    = WR_EN_IN && addr_hit(ADDR_IN, lsi_pkg::OFS_HIGH_LIMIT);
    assign irq_en_wr  = WR_EN_IN && addr_hit(ADDR_IN, lsi_pkg::OFS_IRQ_ENABLE);
    assign irq_clr_wr = WR_EN_IN && addr_hit(ADDR_IN, lsi_pkg::OFS_IRQ_CLEAR);

    assign wr_mode  = WR_DATA_IN[lsi_pkg::CFG_MODE_LSB +: 2];
    assign wr_latch = WR_DATA_IN[lsi_pkg::CFG_LATCH_BIT];

    assign eoc_mode = (low_limit_ff[15:lsi_pkg::EXP_TOP_LSB] == lsi_pkg::EOC_CODE);

    assign alert_taken = ALERT_RESP_IN && latch_ff;

    assign above_high = lsi_linear(RESULT_IN) > lsi_linear(high_limit_ff);
    assign below_low  = lsi_linear(RESULT_IN) < lsi_linear(low_limit_ff);

    lsi_fault_counter #(
        .CNT_W          (lsi_pkg::FAULT_CNT_W)
    ) u_fault_counter (
        .clk_in         (CLK_IN),
        .reset_n_in     (RESET_N_IN),
        .sample_in      (CONV_DONE_IN),
        .above_in       (above_high),
        .below_in       (below_low),
        .fault_sel_in   (fault_sel_ff),
        .high_met_out   (high_met),
        .low_met_out    (low_met)
    );

    // Configuration register, writable fields
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            fault_sel_ff       <= lsi_pkg::RST_FAULT_SEL;
            polarity_select_ff <= lsi_pkg::RST_POL;
            latch_ff           <= lsi_pkg::RST_LATCH;
            conv_mode_ff       <= lsi_pkg::RST_MODE;
        end else if (cfg_wr) begin
            fault_sel_ff       <= WR_DATA_IN[lsi_pkg::CFG_FAULT_LSB +: 2];
            polarity_select_ff <= WR_DATA_IN[lsi_pkg::CFG_POL_BIT];
            latch_ff           <= wr_latch;
            conv_mode_ff       <= wr_mode;
        end
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            low_limit_ff <= lsi_pkg::RST_LOW_LIMIT;
        end else if (low_wr) begin
            low_limit_ff <= WR_DATA_IN;
        end
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            high_limit_ff <= lsi_pkg::RST_HIGH_LIMIT;
        end else if (high_wr) begin
            high_limit_ff <= WR_DATA_IN;
        end
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            result_ff <= lsi_pkg::RST_RESULT;
        end else if (CONV_DONE_IN) begin
            result_ff <= RESULT_IN;
        end
    end

    // Clears first; a conversion in the same cycle wins
    always_comb begin
        nxt_flag_high  = flag_high_ff;
        nxt_flag_low   = flag_low_ff;
        nxt_conv_ready = conv_ready_ff;
        nxt_int_state  = int_state_ff;

        if (cfg_rd) begin
            nxt_conv_ready = 1'b0;
            if (latch_ff) begin
                nxt_flag_high = 1'b0;
                nxt_flag_low  = 1'b0;
                nxt_int_state = lsi_pkg::PIN_INACTIVE;
            end else if (eoc_mode) begin
                nxt_int_state = lsi_pkg::PIN_INACTIVE;
            end
        end

        // Shutdown write leaves conversion-ready as it is, and the pin state unless it drops the latch outside end-of-conversion
        if (cfg_wr && (wr_mode != lsi_pkg::MODE_SHUTDOWN)) begin
            nxt_conv_ready = 1'b0;
            if (eoc_mode && !latch_ff) begin
                nxt_int_state = lsi_pkg::PIN_INACTIVE;
            end
        end

        // Latch drop outside end-of-conversion releases the pin
        if (cfg_wr && !eoc_mode && latch_ff && !wr_latch) begin
            nxt_int_state = lsi_pkg::PIN_INACTIVE;
        end

        if (alert_taken) begin
            nxt_int_state = lsi_pkg::PIN_INACTIVE;
        end

        if (CONV_DONE_IN) begin
            nxt_conv_ready = 1'b1;
            if (high_met) begin
                nxt_flag_high = 1'b1;
                if (!latch_ff) begin
                    nxt_flag_low = 1'b0;
                end
                nxt_int_state = lsi_pkg::PIN_ACTIVE;
            end else if (low_met) begin
                nxt_flag_low = 1'b1;
                if (!latch_ff) begin
                    nxt_flag_high = 1'b0;
                end
                if (eoc_mode || latch_ff) begin
                    nxt_int_state = lsi_pkg::PIN_ACTIVE;
                end else begin
                    nxt_int_state = lsi_pkg::PIN_INACTIVE;
                end
            end else if (eoc_mode) begin
                nxt_int_state = lsi_pkg::PIN_ACTIVE;
            end
        end
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            flag_high_ff <= 1'b0;
            flag_low_ff  <= 1'b0;
        end else begin
            flag_high_ff <= nxt_flag_high;
            flag_low_ff  <= nxt_flag_low;
        end
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            conv_ready_ff <= 1'b0;
        end else begin
            conv_ready_ff <= nxt_conv_ready;
        end
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            int_state_ff <= lsi_pkg::PIN_INACTIVE;
        end else begin
            int_state_ff <= nxt_int_state;
        end
    end

    // Pin uses next state and the polarity being written
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            int_pin_ff <= 1'b1;
        end else if (cfg_wr) begin
            int_pin_ff <= ~(nxt_int_state ^ WR_DATA_IN[lsi_pkg::CFG_POL_BIT]);
        end else begin
            int_pin_ff <= ~(nxt_int_state ^ polarity_select_ff);
        end
    end

    // Acknowledge only while the pin state is active
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            alert_ack_ff       <= 1'b0;
            alert_flag_high_ff <= 1'b0;
        end else begin
            alert_ack_ff       <= alert_taken && (int_state_ff == lsi_pkg::PIN_ACTIVE);
            alert_flag_high_ff <= alert_taken ? flag_high_ff : alert_flag_high_ff;
        end
    end

    always_comb begin
        nxt_rd_data = 16'h0000;
        case (ADDR_IN)
            lsi_pkg::OFS_RESULT: begin
                nxt_rd_data = result_ff;
            end
            lsi_pkg::OFS_CONFIG: begin
                nxt_rd_data[lsi_pkg::CFG_FAULT_LSB +: 2] = fault_sel_ff;
                nxt_rd_data[lsi_pkg::CFG_POL_BIT]        = polarity_select_ff;
                nxt_rd_data[lsi_pkg::CFG_LATCH_BIT]      = latch_ff;
                nxt_rd_data[lsi_pkg::CFG_FLAG_LOW_BIT]   = flag_low_ff;
                nxt_rd_data[lsi_pkg::CFG_FLAG_HIGH_BIT]  = flag_high_ff;
                nxt_rd_data[lsi_pkg::CFG_CONV_RDY_BIT]   = conv_ready_ff;
                nxt_rd_data[lsi_pkg::CFG_MODE_LSB +: 2]  = conv_mode_ff;
            end
            lsi_pkg::OFS_LOW_LIMIT: begin
                nxt_rd_data = low_limit_ff;
            end
            lsi_pkg::OFS_HIGH_LIMIT: begin
                nxt_rd_data = high_limit_ff;
            end
            lsi_pkg::OFS_IRQ_STATUS: begin
                nxt_rd_data[lsi_pkg::IRQ_N-1:0] = irq_status;
            end
            lsi_pkg::OFS_IRQ_ENABLE: begin
                nxt_rd_data[lsi_pkg::IRQ_N-1:0] = irq_enable;
            end
            default: begin
                nxt_rd_data = 16'h0000;
            end
        endcase
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            rd_data_ff <= 16'h0000;
        end else if (RD_EN_IN) begin
            rd_data_ff <= nxt_rd_data;
        end else begin
            rd_data_ff <= 16'h0000;
        end
    end

    always_comb begin
        irq_events                         = '0;
        irq_events[lsi_pkg::IRQ_CONV_BIT]  = CONV_DONE_IN;
        irq_events[lsi_pkg::IRQ_HIGH_BIT]  = high_met;
        irq_events[lsi_pkg::IRQ_LOW_BIT]   = low_met;
        irq_events[lsi_pkg::IRQ_ALERT_BIT] = alert_taken;
    end

    lsi_event_irq #(
        .N              (lsi_pkg::IRQ_N)
    ) u_event_irq (
        .clk_in         (CLK_IN),
        .reset_n_in     (RESET_N_IN),
        .event_in       (irq_events),
        .clear_wr_in    (irq_clr_wr),
        .enable_wr_in   (irq_en_wr),
        .wr_data_in     (WR_DATA_IN[lsi_pkg::IRQ_N-1:0]),
        .status_out     (irq_status),
        .enable_out     (irq_enable),
        .irq_out        (IRQ_OUT)
    );

    assign RD_DATA_OUT         = rd_data_ff;
    assign CONV_MODE_OUT       = conv_mode_ff;
    assign ALERT_ACK_OUT       = alert_ack_ff;
    assign ALERT_FLAG_HIGH_OUT = alert_flag_high_ff;
    assign INT_PIN_OUT         = int_pin_ff;

endmodule

// file: test/lsi_interrupt_core_assertions.sv
`timescale 1ns/100ps
module lsi_interrupt_core_checker (
    // Clock and reset
    input  wire logic        CLK_IN,
    input  wire logic        RESET_N_IN,
    // Register port
    input  wire logic [7:0]  ADDR_IN,
    input  wire logic [15:0] WR_DATA_IN,
    input  wire logic        WR_EN_IN,
    input  wire logic        RD_EN_IN,
    input  wire logic [15:0] RD_DATA_OUT,
    // Events and outputs
    input  wire logic        CONV_DONE_IN,
    input  wire logic        ALERT_RESP_IN,
    input  wire logic        ALERT_ACK_OUT,
    input  wire logic        INT_PIN_OUT
);
    logic      eoc_ff;
    logic      latch_ff;
    logic      pol_ff;
    wire logic cfg_rd = RD_EN_IN && ADDR_IN == lsi_pkg::OFS_CONFIG;
    wire logic cfg_wr = WR_EN_IN && ADDR_IN == lsi_pkg::OFS_CONFIG;
    wire logic run_wr = WR_DATA_IN[lsi_pkg::CFG_MODE_LSB +: 2] != lsi_pkg::MODE_SHUTDOWN;

    // Shadow of the mode bits that steer the pin
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            eoc_ff   <= 1'b0;
            latch_ff <= lsi_pkg::RST_LATCH;
            pol_ff   <= lsi_pkg::RST_POL;
        end else if (WR_EN_IN && ADDR_IN == lsi_pkg::OFS_LOW_LIMIT) begin
            eoc_ff   <= WR_DATA_IN[lsi_pkg::EXP_TOP_LSB +: 2] == lsi_pkg::EOC_CODE;
        end else if (cfg_wr) begin
            latch_ff <= WR_DATA_IN[lsi_pkg::CFG_LATCH_BIT];
            pol_ff   <= WR_DATA_IN[lsi_pkg::CFG_POL_BIT];
        end
    end

    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RESET_N_IN);

    a_eoc_conv_active: assert property (CONV_DONE_IN && eoc_ff |=> INT_PIN_OUT == pol_ff)
        else $error("pin not active after conversion");
    a_read_clears_pin: assert property (cfg_rd && eoc_ff && !CONV_DONE_IN |=> INT_PIN_OUT == !pol_ff)
        else $error("pin not inactive after config read");
    a_run_wr_transp: assert property (cfg_wr && run_wr && eoc_ff && !latch_ff && !CONV_DONE_IN
        |=> INT_PIN_OUT == !pol_ff) else $error("pin not inactive after run write");
    a_shutdown_keeps: assert property (cfg_wr && !run_wr && eoc_ff && !CONV_DONE_IN && !ALERT_RESP_IN
        && WR_DATA_IN[lsi_pkg::CFG_POL_BIT] == pol_ff |=> $stable(INT_PIN_OUT))
        else $error("shutdown write moved the pin");
    a_alert_latched: assert property (ALERT_RESP_IN && latch_ff && !CONV_DONE_IN |=> INT_PIN_OUT == !pol_ff)
        else $error("alert did not release the pin");
    a_alert_ignored: assert property (ALERT_RESP_IN && !latch_ff |=> !ALERT_ACK_OUT)
        else $error("alert answered in transparent mode");
    a_alert_transp: assert property (ALERT_RESP_IN && !latch_ff && eoc_ff && !CONV_DONE_IN
        && !WR_EN_IN && !RD_EN_IN |=> $stable(INT_PIN_OUT)) else $error("alert moved the pin");
    a_ready_after_conv: assert property (CONV_DONE_IN ##1 (!WR_EN_IN && !RD_EN_IN) ##1 cfg_rd
        |=> RD_DATA_OUT[lsi_pkg::CFG_CONV_RDY_BIT]) else $error("ready not set");
    a_second_read: assert property ((cfg_rd && !CONV_DONE_IN) ##1 (!CONV_DONE_IN && !WR_EN_IN)
        ##1 (cfg_rd && !CONV_DONE_IN) |=> !RD_DATA_OUT[lsi_pkg::CFG_CONV_RDY_BIT])
        else $error("ready survived a read");

    c_conv_latched: cover property (CONV_DONE_IN && eoc_ff && latch_ff);
    c_alert_ack: cover property (ALERT_ACK_OUT);
    c_read_transp: cover property (cfg_rd && eoc_ff && !latch_ff);
endmodule

bind lsi_interrupt_core lsi_interrupt_core_checker u_checker (
    .CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN), .ADDR_IN(ADDR_IN), .WR_DATA_IN(WR_DATA_IN),
    .WR_EN_IN(WR_EN_IN), .RD_EN_IN(RD_EN_IN), .RD_DATA_OUT(RD_DATA_OUT),
    .CONV_DONE_IN(CONV_DONE_IN), .ALERT_RESP_IN(ALERT_RESP_IN),
    .ALERT_ACK_OUT(ALERT_ACK_OUT), .INT_PIN_OUT(INT_PIN_OUT));

// file: test/lsi_host_model.sv
`timescale 1ns/100ps
module lsi_host_model (
    // Clock
    input  wire logic        clk_in,
    // Register port toward the device
    input  wire logic [15:0] rd_data_in,
    output logic      [7:0]  addr_out,
    output logic      [15:0] wr_data_out,
    output logic             wr_en_out,
    output logic             rd_en_out
);
    initial begin
        addr_out    = 8'h00;
        wr_data_out = 16'h0000;
        wr_en_out   = 1'b0;
        rd_en_out   = 1'b0;
    end

    // Callers keep the high limit above the low limit
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr_out    <= a;
        wr_data_out <= d;
        wr_en_out   <= 1'b1;
        @(posedge clk_in);
        wr_en_out   <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] q);
        @(posedge clk_in);
        addr_out  <= a;
        rd_en_out <= 1'b1;
        @(posedge clk_in);
        rd_en_out <= 1'b0;
        #1;
        q = rd_data_in;
    endtask

    // Leave end-of-conversion, drop latch to release the pin
    task automatic leave_eoc(input logic [15:0] cfg);
        wr(lsi_pkg::OFS_LOW_LIMIT, 16'h0000);
        wr(lsi_pkg::OFS_CONFIG, cfg & ~16'h0008);
        wr(lsi_pkg::OFS_CONFIG, cfg);
    endtask
endmodule

// file: test/tb_lsi_interrupt_core.sv
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module tb_lsi_interrupt_core;
    logic        clk, rst_n, conv_done, alert_resp;
    logic [15:0] result;
    wire logic [7:0]  addr;
    wire logic [15:0] wr_data;
    wire logic [15:0] rd_data;
    wire logic [1:0]  mode;
    wire logic        wr_en, rd_en, ack, afh, int_pin, irq;
    int          fail_count = 0;
    int          total_checks = 0;
    int          seed = 32'h8317;
    logic        fh = 1'b0, fl = 1'b0, l, p, hi, lo;
    logic [15:0] r;
    logic [15:0] q;

    lsi_interrupt_core u_lsi_interrupt_core (.CLK_IN(clk), .RESET_N_IN(rst_n), .ADDR_IN(addr),
        .WR_DATA_IN(wr_data), .WR_EN_IN(wr_en), .RD_EN_IN(rd_en), .RD_DATA_OUT(rd_data),
        .CONV_DONE_IN(conv_done), .RESULT_IN(result), .CONV_MODE_OUT(mode),
        .ALERT_RESP_IN(alert_resp), .ALERT_ACK_OUT(ack), .ALERT_FLAG_HIGH_OUT(afh),
        .INT_PIN_OUT(int_pin), .IRQ_OUT(irq));
    lsi_host_model u_lsi_host_model (.clk_in(clk), .rd_data_in(rd_data), .addr_out(addr),
        .wr_data_out(wr_data), .wr_en_out(wr_en), .rd_en_out(rd_en));

    function automatic logic [26:0] lin(input logic [15:0] v);
        return 27'(v[11:0]) << v[15:12];
    endfunction
    function automatic logic [15:0] cfg_val(input logic [1:0] m, f, input logic lt, pl,
                                            input logic h = 1'b0, w = 1'b0, rdy = 1'b0);
        return {5'h00, m, 1'b0, rdy, h, w, 1'b0, lt, pl, f};
    endfunction
    function automatic logic pin_lvl(input logic act, input logic pl);
        return ~(act ^ pl);
    endfunction
    task automatic wc(input logic [1:0] m, f, input logic lt, pl);
        u_lsi_host_model.wr(lsi_pkg::OFS_CONFIG, cfg_val(m, f, lt, pl));
    endtask
    task automatic rc;
        u_lsi_host_model.rd(lsi_pkg::OFS_CONFIG, q);
    endtask

    task automatic pulse(input logic is_conv, input logic [15:0] v);
        @(posedge clk);
        conv_done  <= is_conv;
        alert_resp <= !is_conv;
        result     <= v;
        @(posedge clk);
        conv_done  <= 1'b0;
        alert_resp <= 1'b0;
        result     <= ~v;
        #1;
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #100000;
        fail_count++;
        complete_run();
    end

    initial begin
        rst_n = 1'b0;
        conv_done = 1'b0;
        alert_resp = 1'b0;
        result = 16'h0000;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1 `CHK(int_pin, 1'b1)
        u_lsi_host_model.wr(lsi_pkg::OFS_HIGH_LIMIT, 16'hBFFF);
        u_lsi_host_model.wr(lsi_pkg::OFS_LOW_LIMIT, 16'hC100);
        u_lsi_host_model.wr(lsi_pkg::OFS_IRQ_ENABLE, 16'h000F);
        for (int i = 0; i < 24; i++) begin
            l = i >= 12;
            p = 1'($random(seed));
            r = (i % 12 == 0) ? 16'hF800 : (i % 12 == 1) ? 16'h0005 : 16'($random(seed));
            wc(2'h1, 2'h0, l, p);
            pulse(1'b1, r);
            `CHK(int_pin, pin_lvl(1'b1, p))
            `CHK(irq, 1'b1)
            hi = lin(r) > lin(16'hBFFF);
            lo = lin(r) < lin(16'hC100);
            if (l) {fh, fl} = {fh | hi, fl | lo};
            else if (hi | lo) {fh, fl} = {hi, lo};
            pulse(1'b0, 16'h0000);
            `CHK(ack, l)
            `CHK(int_pin, pin_lvl(!l, p))
            if (l) `CHK(afh, fh)
            rc();
            `CHK(q, cfg_val(2'h1, 2'h0, l, p, fh, fl, 1'b1))
            `CHK(int_pin, pin_lvl(1'b0, p))
            if (l) {fh, fl} = 2'b00;
            rc();
            `CHK(q[7:5], {1'b0, fh, fl})
        end
        for (int s = 0; s < 2; s++) begin
            pulse(1'b1, 16'h1000);
            wc(2'(s), 2'h0, 1'b1, 1'b0);
            `CHK(int_pin, 1'b0)
            `CHK(mode, 2'(s))
            rc();
            `CHK(q[7], !s[0])
        end
        wc(2'h1, 2'h0, 1'b0, 1'b0);
        pulse(1'b1, 16'h1000);
        wc(2'h1, 2'h0, 1'b0, 1'b0);
        `CHK(int_pin, 1'b1)
        wc(2'h1, 2'h1, 1'b1, 1'b0);
        rc();
        for (int k = 0; k < 2; k++) begin
            pulse(1'b1, 16'hF800);
            rc();
            `CHK(q[6], k[0])
        end
        pulse(1'b1, 16'h1000);
        u_lsi_host_model.leave_eoc(cfg_val(2'h1, 2'h1, 1'b1, 1'b0));
        `CHK(int_pin, 1'b1)
        u_lsi_host_model.wr(lsi_pkg::OFS_IRQ_CLEAR, 16'h000F);
        `CHK(irq, 1'b0)
        u_lsi_host_model.wr(lsi_pkg::OFS_IRQ_ENABLE, 16'h0000);
        pulse(1'b1, 16'h1000);
        `CHK(irq, 1'b0)
        u_lsi_host_model.rd(lsi_pkg::OFS_IRQ_STATUS, q);
        `CHK(q[0], 1'b1)
        u_lsi_host_model.rd(8'h07, q);
        `CHK(q, 16'h0000)
        u_lsi_host_model.rd(lsi_pkg::OFS_IRQ_CLEAR, q);
        `CHK(q, 16'h0000)
        complete_run();
    end
endmodule
